// *** logic/pcad_config_decode.sv ***
// module: indirect pci configuration access decode top
`timescale 1ns/10ps
module pcad_config_decode
  import pcad_pkg::*;
#(
  parameter int NSLOT = PCAD_NUM_SLOTS
) (
  input  wire logic               clk_sys_in,
  input  wire logic               reset_in,
  input  wire logic               map_b_sel_in,
  input  wire logic               cpu_req_in,
  input  wire logic               cpu_wr_in,
  input  wire logic [31:0]        cpu_addr_in,
  input  wire logic [31:0]        cpu_wdata_in,
  output logic                    cpu_ack_out,
  output logic      [31:0]        cpu_rdata_out,
  output logic                    cfg_req_out,
  output logic                    cfg_wr_out,
  output logic      [31:0]        cfg_addr_out,
  output logic      [3:0]         cfg_be_n_out,
  output logic      [31:0]        cfg_wdata_out,
  input  wire logic               cfg_done_in,
  input  wire logic [31:0]        cfg_rdata_in,
  input  wire logic [4*NSLOT-1:0] slot_int_n_in,
  input  wire logic [3:0]         exp_int_n_in,
  output logic      [NSLOT-1:0]   slot_irq_n_out,
  output logic      [3:0]         exp_irq_n_out
);
  // ============================================================
  // decode helpers
  function automatic pcad_port_type port_of(input logic map_b,
                                            input logic [31:0] a);
    port_of = PCAD_PORT_NONE;
    if (!map_b) begin
      if (a == PCAD_A_ADDR_PORT) port_of = PCAD_PORT_ADDR;
      else if (a[31:2] == PCAD_A_DATA_PORT[31:2])
        port_of = PCAD_PORT_DATA;
    end else if (a[1:0] == 2'h0) begin
      if (a >= PCAD_B_ADDR_LO && a <= PCAD_B_ADDR_HI)
        port_of = PCAD_PORT_ADDR;
      else if (a >= PCAD_B_DATA_LO && a <= PCAD_B_DATA_HI)
        port_of = PCAD_PORT_DATA;
    end
  endfunction

  // one-hot idsel line for on-board device numbers, else none
  function automatic logic [31:0] idsel_of(input logic [4:0] dev);
    idsel_of = 32'h00000000;
    if (dev == PCAD_DEV_BRIDGE || dev == PCAD_DEV_ENET)
      idsel_of[dev] = 1'b1;
    else if (dev >= PCAD_DEV_SLOT_FIRST && dev <= PCAD_DEV_SLOT_LAST)
      idsel_of[dev] = 1'b1;
  endfunction

  // ============================================================
  // state
  logic [31:0]   cfg_addr_reg_ff;
  pcad_cyc_type  cyc_ff;
  pcad_port_type port_now;
  logic [4:0]    dev_now;
  logic          cfg_en_now;
  logic          bus_zero_now;
  logic [3:0]    be_now;

  assign port_now     = port_of(map_b_sel_in, cpu_addr_in);
  assign dev_now      = cfg_addr_reg_ff[PCAD_DEV_LSB +: 5];
  assign cfg_en_now   = cfg_addr_reg_ff[PCAD_EN_BIT];
  assign bus_zero_now = cfg_addr_reg_ff[PCAD_BUS_LSB +: 8] == 8'h00;
  // map b data port is word wide; map a lane picks one byte
  assign be_now = map_b_sel_in ? 4'h0 :
                  ~(4'h1 << cpu_addr_in[1:0]);

  // ============================================================
  // address port: software loads the target register address
  always_ff @(posedge clk_sys_in) begin
    if (reset_in)
      cfg_addr_reg_ff <= PCAD_ADDR_RESET;
    else if (cyc_ff == PCAD_CYC_IDLE && cpu_req_in && cpu_wr_in &&
             port_now == PCAD_PORT_ADDR)
      cfg_addr_reg_ff <= cpu_wdata_in & PCAD_ADDR_WMASK;
  end

  // ============================================================
  // cycle sequencer; unselected devices answer all ones at once
  // so software probing empty slots never hangs the cpu bus
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cyc_ff        <= PCAD_CYC_IDLE;
      cpu_ack_out   <= 1'b0;
      cpu_rdata_out <= 32'h00000000;
      cfg_req_out   <= 1'b0;
      cfg_wr_out    <= 1'b0;
      cfg_addr_out  <= 32'h00000000;
      cfg_be_n_out  <= 4'hF;
      cfg_wdata_out <= 32'h00000000;
    end else begin
      cpu_ack_out <= 1'b0;
      case (cyc_ff)
        PCAD_CYC_IDLE: begin
          if (cpu_req_in && port_now == PCAD_PORT_ADDR) begin
            cpu_ack_out   <= 1'b1;
            cpu_rdata_out <= cfg_addr_reg_ff;
            cyc_ff        <= PCAD_CYC_DONE;
          end else if (cpu_req_in && port_now == PCAD_PORT_DATA) begin
            if (cfg_en_now && bus_zero_now &&
                idsel_of(dev_now) != 32'h00000000) begin
              cfg_req_out   <= 1'b1;
              cfg_wr_out    <= cpu_wr_in;
              cfg_addr_out  <= idsel_of(dev_now) |
                               {21'h00000,
                                cfg_addr_reg_ff[PCAD_FUNC_LSB +: 3],
                                cfg_addr_reg_ff[PCAD_REG_LSB +: 6],
                                2'h0};
              cfg_be_n_out  <= be_now;
              cfg_wdata_out <= cpu_wdata_in;
              cyc_ff        <= PCAD_CYC_WAIT;
            end else begin
              cpu_ack_out   <= 1'b1;
              cpu_rdata_out <= PCAD_DATA_UNMAPPED;
              cyc_ff        <= PCAD_CYC_DONE;
            end
          end else if (cpu_req_in) begin
            cpu_ack_out   <= 1'b1; // unmapped: ack with zero
            cpu_rdata_out <= 32'h00000000;
            cyc_ff        <= PCAD_CYC_DONE;
          end
        end
        PCAD_CYC_WAIT: begin
          if (cfg_done_in) begin
            cfg_req_out   <= 1'b0;
            cfg_be_n_out  <= 4'hF;
            cpu_ack_out   <= 1'b1;
            cpu_rdata_out <= cfg_rdata_in;
            cyc_ff        <= PCAD_CYC_DONE;
          end
        end
        PCAD_CYC_DONE: begin
          // wait for cpu to drop request so one access is one cycle
          if (!cpu_req_in)
            cyc_ff <= PCAD_CYC_IDLE;
        end
        default: cyc_ff <= PCAD_CYC_IDLE;
      endcase
    end
  end

  // ============================================================
  // interrupt routing
  pcad_irq_merge #(
    .NSLOT (NSLOT)
  ) u_irq (
    .clk_sys_in     (clk_sys_in),
    .reset_in       (reset_in),
    .slot_int_n_in  (slot_int_n_in),
    .exp_int_n_in   (exp_int_n_in),
    .slot_irq_n_out (slot_irq_n_out),
    .exp_irq_n_out  (exp_irq_n_out)
  );

  // ============================================================
  // assertions
  addr_load_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (cyc_ff == PCAD_CYC_IDLE && cpu_req_in && cpu_wr_in && !map_b_sel_in &&
     cpu_addr_in == 32'h80000CF8)
    |=> cfg_addr_reg_ff == ($past(cpu_wdata_in) & 32'h80FFFFFC))
    else $error("address port write not stored");
  data_a_hit_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (cyc_ff == PCAD_CYC_IDLE && cpu_req_in && !map_b_sel_in &&
     cpu_addr_in[31:2] == 30'h2000033F && cfg_en_now && bus_zero_now &&
     dev_now == 5'h0E) |=> cfg_req_out && cfg_addr_out[14])
    else $error("map a data port did not start cycle");
  map_b_addr_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (cyc_ff == PCAD_CYC_IDLE && cpu_req_in && cpu_wr_in && map_b_sel_in &&
     cpu_addr_in[31:21] == 11'h7F6 && cpu_addr_in[1:0] == 2'h0)
    |=> cfg_addr_reg_ff == ($past(cpu_wdata_in) & 32'h80FFFFFC))
    else $error("map b address port write lost");
  map_b_data_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (cyc_ff == PCAD_CYC_IDLE && cpu_req_in && map_b_sel_in &&
     cpu_addr_in[31:20] == 12'hFEE && cpu_addr_in[1:0] == 2'h0 &&
     cfg_en_now && bus_zero_now && dev_now == 5'h10)
    |=> cfg_req_out && cfg_be_n_out == 4'h0)
    else $error("map b data port did not start cycle");
  idsel_hot_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $rose(cfg_req_out) |-> $onehot(cfg_addr_out[31:11]))
    else $error("idsel not one-hot");
  idsel_onboard_a: assert property (@(posedge clk_sys_in)
    disable iff (reset_in)
    $rose(cfg_req_out) |-> (cfg_addr_out[13] || cfg_addr_out[14] ||
      cfg_addr_out[19:16] != 4'h0))
    else $error("idsel line outside on-board set");
  slot_idsel_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (cyc_ff == PCAD_CYC_IDLE && cpu_req_in && port_now == PCAD_PORT_DATA &&
     cfg_en_now && bus_zero_now && dev_now == 5'h13)
    |=> cfg_addr_out[19] && cfg_addr_out[18:11] == 8'h00)
    else $error("slot device did not drive its line");
  byte_lane_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (cyc_ff == PCAD_CYC_IDLE && cpu_req_in && !map_b_sel_in &&
     port_now == PCAD_PORT_DATA && cpu_addr_in[1:0] == 2'h2 &&
     cfg_en_now && bus_zero_now && idsel_of(dev_now) != 32'h0)
    |=> cfg_be_n_out == 4'hB)
    else $error("byte enable does not match offset");
  done_ack_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (cyc_ff == PCAD_CYC_WAIT && cfg_done_in)
    |=> cpu_ack_out && !cfg_req_out ##1 !cpu_ack_out)
    else $error("completion not acked for one cycle");
  // a disabled address must answer at once and never reach the pci side
  no_target_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (cyc_ff == PCAD_CYC_IDLE && cpu_req_in && port_now == PCAD_PORT_DATA &&
     !cfg_en_now)
    |=> cpu_ack_out && !cfg_req_out &&
        cpu_rdata_out == 32'hFFFFFFFF)
    else $error("disabled data access started a cycle");

  cfg_read_c: cover property (@(posedge clk_sys_in)
    $rose(cfg_req_out) && !cfg_wr_out ##[1:20] cpu_ack_out);
  cfg_write_c: cover property (@(posedge clk_sys_in)
    $rose(cfg_req_out) && cfg_wr_out);
  map_b_c: cover property (@(posedge clk_sys_in)
    map_b_sel_in && cfg_req_out);
  empty_probe_c: cover property (@(posedge clk_sys_in)
    cpu_ack_out && cpu_rdata_out == 32'hFFFFFFFF);
  unmapped_c: cover property (@(posedge clk_sys_in)
    cyc_ff == PCAD_CYC_IDLE && cpu_req_in && port_now == PCAD_PORT_NONE);
endmodule

// *** logic/pcad_irq_merge.sv ***
// module: pci slot interrupt merge and pass-through
`timescale 1ns/10ps
module pcad_irq_merge
  import pcad_pkg::*;
#(
  parameter int NSLOT = PCAD_NUM_SLOTS
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  input  wire logic [4*NSLOT-1:0] slot_int_n_in,
  input  wire logic [3:0]       exp_int_n_in,
  output logic      [NSLOT-1:0] slot_irq_n_out,
  output logic      [3:0]       exp_irq_n_out
);
  // ============================================================
  // wired-and merge per slot, registered so outputs are flops
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      slot_irq_n_out <= '1;
      exp_irq_n_out  <= 4'hF;
    end else begin
      for (int s = 0; s < NSLOT; s++) begin
        slot_irq_n_out[s] <= &slot_int_n_in[4*s +: 4];
      end
      exp_irq_n_out <= exp_int_n_in;
    end
  end

  merge_low_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    !(&slot_int_n_in[3:0]) |=> !slot_irq_n_out[0])
    else $error("slot 0 interrupt not merged");
  exp_pass_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    ##1 exp_irq_n_out == $past(exp_int_n_in))
    else $error("expansion interrupt not passed through");
endmodule

// *** shared/pcad_pkg.sv ***
// package: constants for the pci configuration access decode block
// ============================================================
// Behaviour
// - config space reached via address then data port
// - map one address port at 0x80000CF8
// - map one data port spans 0x80000CFC-CFF
// - map two address port FEC00000-FEDFFFFF words
// - map two data port FEE00000-FEEFFFFF words
// - device number selects matching AD idsel line
// - device 13 drives AD13, 14 drives AD14
// - devices 16 to 19 drive AD16 to AD19
// - each mezzanine slot merges INTA-INTD to one
// - expansion INTA-INTD pass through as four
package pcad_pkg;
  // ============================================================
  // processor address map
  localparam logic [31:0] PCAD_A_ADDR_PORT    = 32'h80000CF8;
  localparam logic [31:0] PCAD_A_DATA_PORT    = 32'h80000CFC;
  localparam logic [31:0] PCAD_B_ADDR_LO      = 32'hFEC00000;
  localparam logic [31:0] PCAD_B_ADDR_HI      = 32'hFEDFFFFF;
  localparam logic [31:0] PCAD_B_DATA_LO      = 32'hFEE00000;
  localparam logic [31:0] PCAD_B_DATA_HI      = 32'hFEEFFFFF;
  // ============================================================
  // config address register layout
  localparam int          PCAD_EN_BIT         = 31;
  localparam int          PCAD_BUS_LSB        = 16;
  localparam int          PCAD_DEV_LSB        = 11;
  localparam int          PCAD_FUNC_LSB       = 8;
  localparam int          PCAD_REG_LSB        = 2;
  localparam logic [31:0] PCAD_ADDR_RESET     = 32'h00000000;
  localparam logic [31:0] PCAD_ADDR_WMASK     = 32'h80FFFFFC;
  // ============================================================
  // idsel assignments
  localparam logic [4:0]  PCAD_DEV_BRIDGE     = 5'h0D;
  localparam logic [4:0]  PCAD_DEV_ENET       = 5'h0E;
  localparam logic [4:0]  PCAD_DEV_SLOT_FIRST = 5'h10;
  localparam logic [4:0]  PCAD_DEV_SLOT_LAST  = 5'h13;
  localparam int          PCAD_NUM_SLOTS      = 4;
  localparam logic [31:0] PCAD_DATA_UNMAPPED  = 32'hFFFFFFFF;

  typedef enum logic [1:0] {
    PCAD_PORT_NONE,
    PCAD_PORT_ADDR,
    PCAD_PORT_DATA
  } pcad_port_type;

  typedef enum logic [1:0] {
    PCAD_CYC_IDLE,
    PCAD_CYC_WAIT,
    PCAD_CYC_DONE
  } pcad_cyc_type;
endpackage

// *** tb/pcad_tb_target.sv ***
// pci target model that answers config cycles after a chosen latency
`timescale 1ns/10ps
module pcad_tb_target (
  input  wire logic        clk_sys_in,
  input  wire logic        cfg_req_in,
  input  wire logic [31:0] cfg_addr_in,
  input  wire logic [2:0]  lat_in,
  output logic             cfg_done_out,
  output logic      [31:0] cfg_rdata_out
);
  logic [2:0] wait_cnt;

  // ============================================================
  // target response
  initial begin
    wait_cnt = 3'h0;
    cfg_done_out = 1'b0;
    cfg_rdata_out = 32'h0;
  end

  // read data toggles outside done so a stale value never passes
  always @(posedge clk_sys_in) begin
    cfg_done_out  <= 1'b0;
    cfg_rdata_out <= ~cfg_rdata_out;
    if (cfg_req_in && !cfg_done_out) begin
      if (wait_cnt >= lat_in) begin
        cfg_done_out  <= 1'b1;
        cfg_rdata_out <= cfg_addr_in ^ 32'h5A5A5A5A;
        wait_cnt      <= 3'h0;
      end else begin
        wait_cnt <= wait_cnt + 3'h1;
      end
    end
  end
endmodule

// *** tb/tb_pcad_config_decode.sv ***
// self-checking bench for the pci configuration access decode block
`timescale 1ns/10ps
module tb_pcad_config_decode
  import pcad_pkg::*;
;
  logic        clk, rst, map_b, req, wr, ack, cfg_req, cfg_wr;
  logic        cfg_done, seen_wr, prev_req;
  logic [31:0] addr, wdata, rdata, cfg_addr, cfg_wdata, cfg_rdata;
  logic [31:0] seen_addr, seen_wd, q, ex, ap, dp, d, r;
  logic [3:0]  cfg_be_n, seen_be, slot_irq_n, exp_irq_n, exp_int_n;
  logic [15:0] slot_int_n;
  logic [2:0]  lat;
  logic [4:0]  dev;
  int          err_total, samples_checked, cyc_cnt, n0, seed;
  logic [4:0]  devs [6] = '{5'h0D, 5'h0E, 5'h10, 5'h11, 5'h12, 5'h13};
  logic [31:0] bad  [3] = '{32'h00006800, 32'h80007800, 32'h80016800};
  logic [32:0] unm  [4] = '{{1'b0, 32'h80000D00}, {1'b1, 32'hFEE00002},
                            {1'b0, PCAD_B_DATA_LO}, {1'b1, PCAD_A_DATA_PORT}};

  pcad_config_decode i_pcad_config_decode (
    .clk_sys_in(clk), .reset_in(rst), .map_b_sel_in(map_b),
    .cpu_req_in(req), .cpu_wr_in(wr), .cpu_addr_in(addr),
    .cpu_wdata_in(wdata), .cpu_ack_out(ack), .cpu_rdata_out(rdata),
    .cfg_req_out(cfg_req), .cfg_wr_out(cfg_wr), .cfg_addr_out(cfg_addr),
    .cfg_be_n_out(cfg_be_n), .cfg_wdata_out(cfg_wdata),
    .cfg_done_in(cfg_done), .cfg_rdata_in(cfg_rdata),
    .slot_int_n_in(slot_int_n), .exp_int_n_in(exp_int_n),
    .slot_irq_n_out(slot_irq_n), .exp_irq_n_out(exp_irq_n));

  pcad_tb_target i_pcad_tb_target (
    .clk_sys_in(clk), .cfg_req_in(cfg_req), .cfg_addr_in(cfg_addr),
    .lat_in(lat), .cfg_done_out(cfg_done), .cfg_rdata_out(cfg_rdata));

  // ============================================================
  // clock, checks and closing
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // merged slot line is low while any of its four lines is low
  function automatic logic [3:0] mrg(input logic [15:0] v);
    logic [3:0] m;
    for (int s = 0; s < 4; s++) m[s] = &v[4*s +: 4];
    return m;
  endfunction

  // one processor access, held until ack is sampled high
  task automatic access(input logic b, input logic w, input logic [31:0] a,
                        input logic [31:0] dv, output logic [31:0] rq);
    int n;
    @(posedge clk);
    map_b <= b;
    wr    <= w;
    addr  <= a;
    wdata <= dv;
    req   <= 1'b1;
    n = 0;
    // ack and read data are taken at the edge that sees ack high
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    check({31'h0, ack}, 32'h1);
    rq = rdata;
    req <= 1'b0;
  endtask

  // config cycle monitor, sampled mid-cycle where outputs settle
  always @(negedge clk) begin
    prev_req <= cfg_req;
    if (cfg_req === 1'b1) begin
      seen_addr <= cfg_addr;
      seen_be   <= cfg_be_n;
      seen_wd   <= cfg_wdata;
      seen_wr   <= cfg_wr;
    end
    if (cfg_req === 1'b1 && prev_req !== 1'b1) cyc_cnt <= cyc_cnt + 1;
  end

  // hang guard, far beyond the expected run length
  initial begin
    #(20 * 20000);
    err_total++;
    end_of_test();
  end

  // ============================================================
  // main sequence
  initial begin
    seed = 32'h4cc6bf5e;
    {map_b, req, wr, addr, wdata, lat} = '0;
    slot_int_n = 16'hFFFF;
    exp_int_n = 4'hF;
    cyc_cnt = 0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    check({ack, cfg_req, cfg_be_n, slot_irq_n, exp_irq_n}, 32'h0FFF);
    @(posedge clk);
    rst <= 1'b0;
    // every listed target, both maps, every byte lane of map A
    for (int i = 0; i < 8; i++) begin
      r   = $random(seed);
      dev = devs[i % 6];
      lat <= r[30:28];
      ex  = (32'h1 << dev) | (r & 32'h7FC);
      ap  = i[0] ? PCAD_B_ADDR_LO | (i == 1 ? 32'h1FFFFC : r & 32'h1FFFFC)
                 : PCAD_A_ADDR_PORT;
      dp  = i[0] ? PCAD_B_DATA_LO | (i == 3 ? 32'hFFFFC : r & 32'hFFFFC)
                 : PCAD_A_DATA_PORT + (i >> 1);
      d   = 32'h80000000 | {dev, 11'h0} | (r & 32'h7F0007FF);
      access(i[0], 1'b1, ap, d, q);
      access(i[0], 1'b0, ap, 32'h0, q);
      check(q, d & PCAD_ADDR_WMASK);
      n0 = cyc_cnt;
      access(i[0], 1'b0, dp, 32'h0, q);
      check(q, ex ^ 32'h5A5A5A5A);
      check(seen_addr, ex);
      check({31'h0, seen_wr}, 32'h0);
      check({28'h0, seen_be},
            i[0] ? 32'h0 : {28'h0, ~(4'h1 << (i >> 1))});
      access(i[0], 1'b1, dp, r ^ d, q);
      check(seen_wd, r ^ d);
      check({31'h0, seen_wr}, 32'h1);
      check(32'(cyc_cnt), 32'(n0 + 2));
    end
    // disabled, unlisted device and nonzero bus: no pci cycle
    for (int i = 0; i < 3; i++) begin
      n0 = cyc_cnt;
      access(1'b0, 1'b1, PCAD_A_ADDR_PORT, bad[i], q);
      access(1'b0, 1'b0, PCAD_A_DATA_PORT, 32'h0, q);
      check(q, PCAD_DATA_UNMAPPED);
      check(32'(cyc_cnt), 32'(n0));
    end
    // an unmapped map A address, ports of the other map and unaligned map B read as zero
    for (int i = 0; i < 4; i++) begin
      access(unm[i][32], 1'b0, unm[i][31:0], 32'h0, q);
      check(q, 32'h0);
    end
    // interrupt merge and pass-through, one cycle behind
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      @(posedge clk);
      slot_int_n <= r[15:0] | r[31:16];
      exp_int_n  <= r[3:0];
      @(posedge clk);
      @(negedge clk);
      check({28'h0, slot_irq_n}, {28'h0, mrg(r[15:0] | r[31:16])});
      check({28'h0, exp_irq_n}, {28'h0, r[3:0]});
    end
    end_of_test();
  end
endmodule
